// >>> include/dual_space_pkg.sv
// Purpose: Shared constants and types for the dual data space access paths.
// Assumes: 16-bit data words, byte-free word addressing of the data space.
// Notes:   Boundary and sizes are per-variant elaboration constants.
package dual_space_pkg;
	localparam int unsigned DATA_W      = 16;
	localparam int unsigned ADDR_W      = 16;
	localparam logic [15:0] Y_BASE_DEF  = 16'h1000;
	localparam logic [15:0] Y_END_DEF   = 16'h1FFF;
	localparam logic [15:0] RESET_ADDR  = 16'h0000;
	localparam logic [15:0] RESET_DATA  = 16'h0000;

	typedef enum logic [1:0] {
		AM_LINEAR  = 2'h0,
		AM_MODULO  = 2'h1,
		AM_BITREV  = 2'h3
	} addr_mode_t;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'h0,
		ST_ACCESS  = 2'h1,
		ST_RESP    = 2'h3
	} path_state_t;
endpackage

// >>> include/agu_if.sv
// Purpose: Carrier between the top and one address generator instance.
// Assumes: Single clock domain.
// Notes:   Modulo window given as start and end, inclusive.
`timescale 1ns/1ps
interface agu_if;
	import dual_space_pkg::*;
	logic        [15:0] base;
	logic        [15:0] offset;
	logic        [15:0] mod_start;
	logic        [15:0] mod_end;
	addr_mode_t         mode;
	logic        [15:0] ea;
	modport gen (input base, offset, mod_start, mod_end, mode, output ea);
	modport use_side (output base, offset, mod_start, mod_end, mode, input ea);
endinterface

// >>> src/address_generator.sv
// Purpose: Effective address computation for one data path.
// Assumes: Offsets are word steps; modulo window is nonempty.
// Notes:   Bit-reverse works on the low REV_W bits of the base.
`timescale 1ns/1ps
module address_generator
	import dual_space_pkg::*;
#(
	parameter bit          HAS_MODULO = 1'b1,
	parameter bit          HAS_BITREV = 1'b1,
	parameter int unsigned REV_W      = 8
) (
	agu_if.gen agu
);
	// The reversal must stay inside the 16-bit word
	if (REV_W < 1 || REV_W > 16) begin
		$error("address_generator: REV_W out of range");
	end

	logic [15:0] sum;
	logic [15:0] rev;
	logic [15:0] wrapped;

	always_comb begin
		sum = 16'(agu.base + agu.offset);
		rev = agu.base;
		for (int i = 0; i < REV_W; i++) begin
			rev[i] = agu.base[REV_W - 1 - i];
		end
		// Wrap past either end of the circular window
		if (sum > agu.mod_end) begin
			wrapped = 16'(sum - agu.mod_end + agu.mod_start - 16'h0001);
		end else if (sum < agu.mod_start) begin
			wrapped = 16'(agu.mod_end - (agu.mod_start - sum) + 16'h0001);
		end else begin
			wrapped = sum;
		end
		case (agu.mode)
			AM_MODULO: agu.ea = HAS_MODULO ? wrapped : sum;
			AM_BITREV: agu.ea = HAS_BITREV ? rev : sum;
			default:   agu.ea = sum;
		endcase
	end
endmodule

// >>> src/dual_space_access.sv
// Purpose: X/Y data space routing with two address generators.
// Assumes: RAM answers reads combinationally in the cycle of the read strobe.
// Notes:   X/Y boundary is fixed by parameters; nothing writable moves it.
//          An out-of-region Y operand costs one extra cycle on the X read bus.
//          Requests that arrive while an access is in flight are ignored.
//
// Summary of operation
// - Separate X/Y for dual ops, unified otherwise.
// - Two address generators, two data paths.
// - X serves every instruction and mode.
// - X has separate read and write buses.
// - X read carries unified reads, out-of-region Y reads.
// - Y read only with X in dual ops.
// - Modulo addressing on X and Y.
// - Bit-reverse only on X writes.
// - Reduced variant drops modulo and bit-reverse.
// - All writes use unified linear space.
// - X/Y boundary fixed per variant.
`timescale 1ns/1ps
module dual_space_access
	import dual_space_pkg::*;
#(
	parameter logic [15:0] Y_BASE  = Y_BASE_DEF,
	parameter logic [15:0] Y_END   = Y_END_DEF,
	parameter bit          DSP_VAR = 1'b1
) (
	input  wire logic        i_mclk,
	input  wire logic        i_rst_n,
	input  wire logic        i_ce,
	input  wire logic        i_req,
	input  wire logic        i_dual,
	input  wire logic        i_wr,
	input  wire logic [15:0] i_x_base,
	input  wire logic [15:0] i_x_offset,
	input  wire logic [1:0]  i_x_mode,
	input  wire logic [15:0] i_y_base,
	input  wire logic [15:0] i_y_offset,
	input  wire logic [1:0]  i_y_mode,
	input  wire logic [15:0] i_mod_start,
	input  wire logic [15:0] i_mod_end,
	input  wire logic [15:0] i_wdata,
	input  wire logic [15:0] i_x_rdata,
	input  wire logic [15:0] i_y_rdata,
	output logic             o_x_rd,
	output logic      [15:0] o_x_raddr,
	output logic             o_x_wr,
	output logic      [15:0] o_x_waddr,
	output logic      [15:0] o_x_wdata,
	output logic             o_y_rd,
	output logic      [15:0] o_y_raddr,
	output logic             o_valid,
	output logic      [15:0] o_x_data,
	output logic      [15:0] o_y_data
);
	// Boundary is fixed at elaboration so nothing writable can move it
	if (Y_BASE > Y_END) begin
		$error("dual_space_access: Y region is empty");
	end
	if (Y_BASE == 16'h0000 && Y_END == 16'hFFFF) begin
		$error("dual_space_access: no room left for the X region");
	end

	agu_if x_agu ();
	agu_if y_agu ();

	address_generator #(
		.HAS_MODULO (DSP_VAR),
		.HAS_BITREV (DSP_VAR),
		.REV_W      (8)
	) u_x_gen (
		.agu (x_agu.gen)
	);

	address_generator #(
		.HAS_MODULO (DSP_VAR),
		.HAS_BITREV (1'b0),
		.REV_W      (8)
	) u_y_gen (
		.agu (y_agu.gen)
	);

	addr_mode_t x_mode_sel;
	addr_mode_t y_mode_sel;
	logic       y_in_region;

	// The spare mode code runs as linear instead of being refused
	always_comb begin
		case (i_x_mode)
			AM_MODULO: x_mode_sel = AM_MODULO;
			// Bit-reverse is a write-only mode; reads fall back to linear
			AM_BITREV: x_mode_sel = i_wr ? AM_BITREV : AM_LINEAR;
			default:   x_mode_sel = AM_LINEAR;
		endcase
		case (i_y_mode)
			AM_MODULO: y_mode_sel = AM_MODULO;
			default:   y_mode_sel = AM_LINEAR;
		endcase
	end

	always_comb begin
		x_agu.base      = i_x_base;
		x_agu.offset    = i_x_offset;
		x_agu.mod_start = i_mod_start;
		x_agu.mod_end   = i_mod_end;
		x_agu.mode      = x_mode_sel;
		y_agu.base      = i_y_base;
		y_agu.offset    = i_y_offset;
		y_agu.mod_start = i_mod_start;
		y_agu.mod_end   = i_mod_end;
		y_agu.mode      = y_mode_sel;
	end

	path_state_t state_q, state_d;
	logic        y_pend_q, y_pend_d;
	logic        y_via_x_q, y_via_x_d;
	logic [15:0] y_alt_q, y_alt_d;

	logic        x_wr_q, x_wr_d;
	logic [15:0] x_waddr_q, x_waddr_d;
	logic [15:0] x_wdata_q, x_wdata_d;

	logic        x_rd_q, x_rd_d;
	logic [15:0] x_raddr_q, x_raddr_d;
	logic        y_rd_q, y_rd_d;
	logic [15:0] y_raddr_q, y_raddr_d;

	logic        valid_q, valid_d;
	logic [15:0] x_data_q, x_data_d;
	logic [15:0] y_data_q, y_data_d;

	logic        take;
	logic        take_wr;
	logic        take_rd;
	logic        take_y_rd;
	logic        take_y_alt;

	// Request decode, shared by the control, write and read-strobe groups below
	always_comb begin
		y_in_region = (y_agu.ea >= Y_BASE) && (y_agu.ea <= Y_END);
		take        = (state_q == ST_IDLE) && i_req;
		take_wr     = take && i_wr;
		take_rd     = take && !i_wr;
		take_y_rd   = take_rd && i_dual && y_in_region;
		take_y_alt  = take_rd && i_dual && !y_in_region;
	end

	// Request control: which step of an access the block is in
	always_comb begin
		state_d   = state_q;
		y_pend_d  = y_pend_q;
		y_via_x_d = y_via_x_q;
		y_alt_d   = y_alt_q;
		case (state_q)
			ST_IDLE: begin
				if (take_wr) begin
					state_d = ST_RESP;
				end else if (take_rd) begin
					y_pend_d  = i_dual;
					y_via_x_d = take_y_alt;
					// Capture the Y address now; request inputs may move on
					y_alt_d   = y_agu.ea;
					state_d   = ST_ACCESS;
				end
			end
			ST_ACCESS: begin
				// Only the out-of-region case needs the extra step
				if (y_via_x_q) begin
					state_d = ST_RESP;
				end else begin
					state_d = ST_IDLE;
				end
			end
			ST_RESP: begin
				y_via_x_d = 1'b0;
				state_d   = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q   <= ST_IDLE;
			y_pend_q  <= 1'b0;
			y_via_x_q <= 1'b0;
			y_alt_q   <= RESET_ADDR;
		end else if (i_ce) begin
			state_q   <= state_d;
			y_pend_q  <= y_pend_d;
			y_via_x_q <= y_via_x_d;
			y_alt_q   <= y_alt_d;
		end
	end

	// X write path: its own bus, never shared with the read strobes
	always_comb begin
		x_wr_d    = 1'b0;
		x_waddr_d = x_waddr_q;
		x_wdata_d = x_wdata_q;
		if (take_wr) begin
			// Writes always land in the unified space through X
			x_wr_d    = 1'b1;
			x_waddr_d = x_agu.ea;
			x_wdata_d = i_wdata;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			x_wr_q    <= 1'b0;
			x_waddr_q <= RESET_ADDR;
			x_wdata_q <= RESET_DATA;
		end else if (i_ce) begin
			x_wr_q    <= x_wr_d;
			x_waddr_q <= x_waddr_d;
			x_wdata_q <= x_wdata_d;
		end
	end

	// Read strobes for both paths
	always_comb begin
		x_rd_d    = 1'b0;
		x_raddr_d = x_raddr_q;
		y_rd_d    = 1'b0;
		y_raddr_d = y_raddr_q;
		if (take_rd) begin
			x_rd_d    = 1'b1;
			x_raddr_d = x_agu.ea;
		end else if (state_q == ST_ACCESS && y_via_x_q) begin
			// Out-of-region Y operand costs a second X read
			x_rd_d    = 1'b1;
			x_raddr_d = y_alt_q;
		end
		if (take_y_rd) begin
			y_rd_d    = 1'b1;
			y_raddr_d = y_agu.ea;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			x_rd_q    <= 1'b0;
			x_raddr_q <= RESET_ADDR;
			y_rd_q    <= 1'b0;
			y_raddr_q <= RESET_ADDR;
		end else if (i_ce) begin
			x_rd_q    <= x_rd_d;
			x_raddr_q <= x_raddr_d;
			y_rd_q    <= y_rd_d;
			y_raddr_q <= y_raddr_d;
		end
	end

	// Operand capture: RAM data is due in the same cycle as its strobe
	always_comb begin
		valid_d  = 1'b0;
		x_data_d = x_data_q;
		y_data_d = y_data_q;
		case (state_q)
			ST_ACCESS: begin
				x_data_d = i_x_rdata;
				if (!y_via_x_q) begin
					// A single-operand read reports zero for the Y operand
					y_data_d = y_pend_q ? i_y_rdata : RESET_DATA;
					valid_d  = 1'b1;
				end
			end
			ST_RESP: begin
				if (y_via_x_q) begin
					y_data_d = i_x_rdata;
				end
				valid_d = 1'b1;
			end
			default: begin
				valid_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			valid_q  <= 1'b0;
			x_data_q <= RESET_DATA;
			y_data_q <= RESET_DATA;
		end else if (i_ce) begin
			valid_q  <= valid_d;
			x_data_q <= x_data_d;
			y_data_q <= y_data_d;
		end
	end

	assign o_x_rd    = x_rd_q;
	assign o_x_raddr = x_raddr_q;
	assign o_x_wr    = x_wr_q;
	assign o_x_waddr = x_waddr_q;
	assign o_x_wdata = x_wdata_q;
	assign o_y_rd    = y_rd_q;
	assign o_y_raddr = y_raddr_q;
	assign o_valid   = valid_q;
	assign o_x_data  = x_data_q;
	assign o_y_data  = y_data_q;
endmodule

// >>> verif/dual_space_access_sva.sv
// Purpose: Port checks for the dual data space access block.
// Assumes: i_ce is never low while o_x_wr, o_y_rd or o_valid is high.
// Notes: Bound from the bench top file.
`timescale 1ns/1ps
module dual_space_access_sva
	import dual_space_pkg::*;
#(
	parameter logic [15:0] Y_BASE = Y_BASE_DEF,
	parameter logic [15:0] Y_END  = Y_END_DEF
) (
	input wire logic        i_mclk,
	input wire logic        i_rst_n,
	input wire logic [15:0] i_wdata,
	input wire logic [15:0] i_y_rdata,
	input wire logic        o_x_rd,
	input wire logic        o_x_wr,
	input wire logic [15:0] o_x_wdata,
	input wire logic        o_y_rd,
	input wire logic [15:0] o_y_raddr,
	input wire logic        o_valid,
	input wire logic [15:0] o_y_data
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);
	sequence s_done;
		##1 o_valid;
	endsequence
	a_wr_done: assert property (o_x_wr |-> s_done)
		else $error("write did not complete");
	a_wr_data: assert property (o_x_wr |-> o_x_wdata == $past(i_wdata))
		else $error("write data changed");
	a_rw_split: assert property (!(o_x_wr && o_x_rd))
		else $error("read and write share a cycle");
	a_y_with_x: assert property (o_y_rd |-> o_x_rd)
		else $error("Y read without X read");
	a_y_range: assert property (o_y_rd |-> o_y_raddr >= Y_BASE && o_y_raddr <= Y_END)
		else $error("Y read outside Y region");
	a_y_data: assert property (o_y_rd |=> o_valid && o_y_data == $past(i_y_rdata))
		else $error("Y operand lost");
	a_x_rd_next: assert property (o_x_rd |-> ##1 (o_valid || o_x_rd))
		else $error("X read not followed up");
	a_valid_once: assert property (o_valid |=> !o_valid)
		else $error("valid held too long");
endmodule

// >>> verif/ram_model.sv
// Purpose: Data RAM stand-in answering X and Y reads.
// Assumes: Read data is due in the cycle of the read strobe.
// Notes: Idle data lines show the inverse of the last value.
`timescale 1ns/1ps
module ram_model (
	input wire logic        i_mclk,
	input wire logic        i_x_rd,
	input wire logic [15:0] i_x_raddr,
	input wire logic        i_y_rd,
	input wire logic [15:0] i_y_raddr,
	output logic     [15:0] o_x_rdata,
	output logic     [15:0] o_y_rdata
);
	logic [15:0] x_last_q = 16'h0000;
	logic [15:0] y_last_q = 16'h0000;
	always_ff @(posedge i_mclk) begin
		x_last_q <= o_x_rdata;
		y_last_q <= o_y_rdata;
	end
	// Distinct keys per path expose data taken from the wrong bus
	assign o_x_rdata = i_x_rd ? (i_x_raddr ^ 16'h5A5A) : ~x_last_q;
	assign o_y_rdata = i_y_rd ? (i_y_raddr ^ 16'hC3C3) : ~y_last_q;
endmodule

// >>> verif/dual_space_access_tb.sv
// Purpose: Self-checking bench for the dual data space access block.
// Assumes: Mod window 0800..080F, default Y region.
// Notes: Variant parameters are not swept.
`timescale 1ns/1ps
module dual_space_access_tb;
	import dual_space_pkg::*;
	localparam logic [15:0] XK = 16'h5A5A;
	localparam logic [15:0] YK = 16'hC3C3;
	logic        i_mclk = 1'b0, i_rst_n = 1'b0, i_req = 1'b0, i_dual = 1'b0, i_wr = 1'b0;
	logic        i_ce = 1'b1;
	logic [15:0] i_x_base = 16'h0000, i_x_offset = 16'h0000, i_wdata = 16'h0000;
	logic [15:0] i_y_base = 16'h0000, i_y_offset = 16'h0000;
	logic [1:0]  i_x_mode = 2'h0, i_y_mode = 2'h0;
	logic        o_x_rd, o_x_wr, o_y_rd, o_valid;
	logic [15:0] o_x_raddr, o_x_waddr, o_x_wdata, o_y_raddr, o_x_data, o_y_data, xr, yr;
	logic [15:0] xa [4], ya [4];
	logic [31:0] wa [4];
	int          nx, ny, nw, cycles = 0, num_errors = 0, comparisons = 0;
	always #10 i_mclk = ~i_mclk;
	dual_space_access uut (.i_mclk, .i_rst_n, .i_ce, .i_req, .i_dual, .i_wr, .i_x_base,
		.i_x_offset, .i_x_mode, .i_y_base, .i_y_offset, .i_y_mode, .i_mod_start(16'h0800),
		.i_mod_end(16'h080F), .i_wdata, .i_x_rdata(xr), .i_y_rdata(yr), .o_x_rd, .o_x_raddr,
		.o_x_wr, .o_x_waddr, .o_x_wdata, .o_y_rd, .o_y_raddr, .o_valid, .o_x_data, .o_y_data);
	ram_model ram (.i_mclk, .i_x_rd(o_x_rd), .i_x_raddr(o_x_raddr), .i_y_rd(o_y_rd),
		.i_y_raddr(o_y_raddr), .o_x_rdata(xr), .o_y_rdata(yr));
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic op(input logic wr, dual, input logic [15:0] xb, xo, input logic [1:0] xm,
		input logic [15:0] yb, yo, input logic [1:0] ym);
		@(posedge i_mclk);
		i_req <= 1'b1;
		{i_wr, i_dual, i_x_base, i_x_offset, i_x_mode} <= {wr, dual, xb, xo, xm};
		{i_y_base, i_y_offset, i_y_mode, i_wdata} <= {yb, yo, ym, xb + 16'h0F0F};
		nx = 0;
		ny = 0;
		nw = 0;
		@(posedge i_mclk);
		i_req <= 1'b0;
		for (int k = 0; k < 8; k++) begin
			#1;
			if (o_x_rd === 1'b1) xa[nx++] = o_x_raddr;
			if (o_y_rd === 1'b1) ya[ny++] = o_y_raddr;
			if (o_x_wr === 1'b1) wa[nw++] = {o_x_waddr, o_x_wdata};
			if (o_valid === 1'b1) break;
			@(posedge i_mclk);
		end
		cmp({15'h0000, o_valid}, 16'h0001);
	endtask
	task automatic t_write;
		op(1'b1, 1'b0, 16'h1000, 16'h0010, AM_LINEAR, 16'h0000, 16'h0000, AM_LINEAR);
		cmp(wa[0][31:16], 16'h1010);
		cmp(wa[0][15:0], 16'h1F0F);
		cmp(16'(nx), 16'h0000);
	endtask
	task automatic t_bitrev;
		op(1'b1, 1'b0, 16'h1201, 16'h0005, AM_BITREV, 16'h0000, 16'h0000, AM_LINEAR);
		cmp(wa[0][31:16], 16'h1280);
	endtask
	task automatic t_read;
		op(1'b0, 1'b0, 16'h0100, 16'h0002, AM_BITREV, 16'h0000, 16'h0000, AM_LINEAR);
		cmp(xa[0], 16'h0102);
		cmp(o_x_data, 16'h0102 ^ XK);
		cmp(16'(ny), 16'h0000);
		cmp(o_y_data, 16'h0000);
	endtask
	task automatic t_freeze;
		@(posedge i_mclk);
		{i_req, i_wr, i_dual, i_x_mode, i_x_offset} <= {1'b1, 1'b0, 1'b0, 2'h0, 16'h0000};
		i_x_base <= 16'h0040;
		@(posedge i_mclk);
		{i_req, i_ce} <= 2'b00;
		repeat (3) @(posedge i_mclk);
		#1;
		cmp({15'h0000, o_valid}, 16'h0000);
		cmp({15'h0000, o_x_rd}, 16'h0001);
		cmp(o_x_raddr, 16'h0040);
		@(posedge i_mclk);
		i_ce <= 1'b1;
		@(posedge i_mclk);
		#1;
		cmp({15'h0000, o_valid}, 16'h0001);
		cmp(o_x_data, 16'h0040 ^ XK);
	endtask
	task automatic t_dual;
		op(1'b0, 1'b1, 16'h0200, 16'h0001, AM_LINEAR, 16'h1000, 16'h0FFF, AM_LINEAR);
		cmp(ya[0], 16'h1FFF);
		cmp(o_x_data, 16'h0201 ^ XK);
		cmp(o_y_data, 16'h1FFF ^ YK);
	endtask
	task automatic t_dual_out;
		op(1'b0, 1'b1, 16'h0300, 16'h0000, AM_LINEAR, 16'h0FFF, 16'h0000, AM_BITREV);
		cmp(16'(ny), 16'h0000);
		cmp(xa[1], 16'h0FFF);
		cmp(o_y_data, 16'h0FFF ^ XK);
		cmp(o_x_data, 16'h0300 ^ XK);
	endtask
	task automatic t_modulo;
		op(1'b0, 1'b1, 16'h080E, 16'h0004, AM_MODULO, 16'h0801, 16'hFFFE, AM_MODULO);
		cmp(xa[0], 16'h0802);
		cmp(xa[1], 16'h080F);
		cmp(o_y_data, 16'h080F ^ XK);
	endtask
	task automatic print_verdict;
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Whole run needs about 47 cycles
	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 2000) begin
			num_errors++;
			print_verdict();
		end
	end
	initial begin
		repeat (20) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		t_write();
		t_bitrev();
		t_read();
		t_freeze();
		t_dual();
		t_dual_out();
		t_modulo();
		print_verdict();
	end
endmodule
bind dual_space_access dual_space_access_sva #(.Y_BASE(Y_BASE), .Y_END(Y_END)) u_sva (
	.i_mclk, .i_rst_n, .i_wdata, .i_y_rdata, .o_x_rd, .o_x_wr, .o_x_wdata, .o_y_rd,
	.o_y_raddr, .o_valid, .o_y_data);
